/* board_straps.sv */
`timescale 1ns/1ns
module board_straps (
   input  wire logic [2:0] i_core_code,
   input  wire logic [2:0] i_mem_code,
   output logic      [2:0] o_core_pins,
   output logic      [2:0] o_mem_pins
);
   assign o_core_pins = i_core_code;
   assign o_mem_pins  = i_mem_code;
endmodule // board_straps

/* clock_ratio_defines.svh */
`ifndef CLOCK_RATIO_DEFINES_SVH
`define CLOCK_RATIO_DEFINES_SVH

// Core to platform ratio codes.
`define CORE_CODE_4_1      3'h0
`define CORE_CODE_9_2      3'h1
`define CORE_CODE_RSVD     3'h2
`define CORE_CODE_3_2      3'h3
`define CORE_CODE_2_1      3'h4
`define CORE_CODE_5_2      3'h5
`define CORE_CODE_3_1      3'h6
`define CORE_CODE_7_2      3'h7

// Memory PLL ratio codes.
`define MEM_CODE_3_1       3'h0
`define MEM_CODE_4_1       3'h1
`define MEM_CODE_6_1       3'h2
`define MEM_CODE_8_1       3'h3
`define MEM_CODE_10_1      3'h4
`define MEM_CODE_12_1      3'h5
`define MEM_CODE_RSVD      3'h6
`define MEM_CODE_SYNC      3'h7

// PCI input clock range in MHz.
`define PCI_CLK_MIN_MHZ    8'h21
`define PCI_CLK_MAX_MHZ    8'h42

// Minimum platform clock for PCI Express: 527 MHz times lanes over 8.
`define PCIE_BASE_MHZ      16'h020f
`define PCIE_LANE_DIV      16'h0008

// Reset values of the latched ratios.
`define RST_CORE_NUM       4'h0
`define RST_CORE_DEN       2'h1
`define RST_MEM_MULT       4'h0

`endif

/* clock_ratio_pkg.sv */
package clock_ratio_pkg;

   typedef struct packed {
      logic [3:0] numer;
      logic [1:0] denom;
   } core_ratio_t;

   typedef struct packed {
      logic       sync_mode;
      logic [3:0] mult;
      logic       half_speed;
   } mem_clock_t;

   typedef enum logic [1:0] {
      ST_WAIT_POR = 2'b00,
      ST_SAMPLE   = 2'b01,
      ST_LOCKED   = 2'b11
   } latch_state_t;

endpackage

/* clock_ratio_strap_decode.sv */
`timescale 1ns/1ns
`include "clock_ratio_defines.svh"
// What this block does
// - Sample core ratio straps at power-up.
// - Decode core ratio code; 010 reserved.
// - Memory clocking synchronous or own PLL.
// - Synchronous mode: memory bus half platform.
// - Data rate equals platform or PLL rate.
// - Async ratio is data rate over reference.
// - Divider register halves memory bus clock.
// - Decode memory PLL strap; 111 sync.
// - PCI input clock from 33 to 66 MHz.
// - PCI clock from system or dedicated input.

module clock_ratio_strap_decode
   import clock_ratio_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic        i_local_bus_control_strap,
   input  wire logic        i_address_latch_enable_strap,
   input  wire logic        i_general_purpose_line_two_strap,
   input  wire logic [1:0]  i_timestamp_trigger_output_pins,
   input  wire logic        i_timestamp_clock_output_pin,
   input  wire logic        i_memory_clock_divider_register,
   input  wire logic        i_memory_init_started,
   input  wire logic        i_pci_async_mode,
   input  wire logic [7:0]  i_system_reference_clock_mhz,
   input  wire logic [15:0] i_platform_bus_clock_mhz,
   input  wire logic [4:0]  i_negotiated_link_width,
   output core_ratio_t      o_core_ratio,
   output mem_clock_t       o_mem_clock,
   output logic             o_mem_ref_clock_needed,
   output logic             o_pci_clock_from_dedicated,
   output logic             o_pci_clock_in_range,
   output logic             o_pcie_platform_too_slow,
   output logic             o_config_error,
   output logic             o_straps_locked
);

   ////////////////////////////////////////////////////////////////////////////////
   // Strap capture.

   latch_state_t state_reg;
   latch_state_t state_next;
   logic [2:0]   core_code_reg;
   logic [2:0]   mem_code_reg;
   logic [2:0]   core_pins;
   logic [2:0]   mem_pins;
   core_ratio_t  core_dec;
   logic         core_rsvd;

   assign core_pins = {i_local_bus_control_strap, i_address_latch_enable_strap,
                       i_general_purpose_line_two_strap};
   assign mem_pins  = {i_timestamp_trigger_output_pins, i_timestamp_clock_output_pin};

   // Straps are caught by a clocked sample after release, never by the reset itself.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_WAIT_POR: state_next = ST_SAMPLE;
         ST_SAMPLE:   state_next = ST_LOCKED;
         ST_LOCKED:   state_next = ST_LOCKED;
         default:     state_next = ST_WAIT_POR;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         state_reg <= ST_WAIT_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         core_code_reg <= `CORE_CODE_4_1;
         mem_code_reg  <= `MEM_CODE_SYNC;
      end else if (state_reg == ST_SAMPLE) begin
         core_code_reg <= core_pins;
         mem_code_reg  <= mem_pins;
      end
   end

   assign o_straps_locked = (state_reg == ST_LOCKED);

   ////////////////////////////////////////////////////////////////////////////////
   // Decoders.

   core_ratio_decode u_core_decode (
      .i_code     (core_code_reg),
      .o_ratio    (core_dec),
      .o_reserved (core_rsvd)
   );

   function automatic logic [3:0] mem_mult(input logic [2:0] code);
      logic [3:0] m;
      m = 4'h0;
      unique case (code)
         `MEM_CODE_3_1:  m = 4'h3;
         `MEM_CODE_4_1:  m = 4'h4;
         `MEM_CODE_6_1:  m = 4'h6;
         `MEM_CODE_8_1:  m = 4'h8;
         `MEM_CODE_10_1: m = 4'ha;
         `MEM_CODE_12_1: m = 4'hc;
         `MEM_CODE_RSVD: m = 4'h0;
         `MEM_CODE_SYNC: m = 4'h0;
      endcase
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Registered ratio outputs.

   logic mem_sync;
   assign mem_sync = (mem_code_reg == `MEM_CODE_SYNC);

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_core_ratio <= '{numer: `RST_CORE_NUM, denom: `RST_CORE_DEN};
      end else if (o_straps_locked) begin
         o_core_ratio <= core_dec;
      end
   end

   // In sync mode mult is zero: data rate equals platform rate and the bus runs at half.
   // In async mode mult is data rate over the memory reference clock.
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_mem_clock <= '{sync_mode: 1'b1, mult: `RST_MEM_MULT, half_speed: 1'b0};
      end else if (o_straps_locked) begin
         o_mem_clock.sync_mode <= mem_sync;
         o_mem_clock.mult      <= mem_mult(mem_code_reg);
         // The divider is taken only before memory init; later changes are ignored.
         if (!i_memory_init_started) begin
            o_mem_clock.half_speed <= i_memory_clock_divider_register;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_mem_ref_clock_needed <= 1'b0;
      end else begin
         o_mem_ref_clock_needed <= o_straps_locked && !mem_sync;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_config_error <= 1'b0;
      end else if (o_straps_locked) begin
         o_config_error <= core_rsvd || (mem_code_reg == `MEM_CODE_RSVD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // PCI and PCI Express clock checks.

   logic        sys_in_range;
   logic [20:0] pcie_need_x8;
   logic [18:0] plat_x8;

   assign sys_in_range = (i_system_reference_clock_mhz >= `PCI_CLK_MIN_MHZ) &&
                         (i_system_reference_clock_mhz <= `PCI_CLK_MAX_MHZ);
   // Compare platform*8 against 527*width to avoid a divider.
   assign pcie_need_x8 = 21'(`PCIE_BASE_MHZ) * 21'(i_negotiated_link_width);
   assign plat_x8      = 19'(i_platform_bus_clock_mhz) * 19'(`PCIE_LANE_DIV);

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_pci_clock_from_dedicated <= 1'b0;
         o_pci_clock_in_range       <= 1'b0;
      end else begin
         // Out of range system clock forces the dedicated input.
         o_pci_clock_from_dedicated <= i_pci_async_mode || !sys_in_range;
         o_pci_clock_in_range       <= i_pci_async_mode || sys_in_range;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_pcie_platform_too_slow <= 1'b0;
      end else begin
         o_pcie_platform_too_slow <= {2'b00, plat_x8} < pcie_need_x8;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   strap_sample_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      state_reg == ST_SAMPLE |=> core_code_reg == $past(core_pins))
      else $error("core strap not sampled");

   strap_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      $past(o_straps_locked) |-> $stable(core_code_reg) && $stable(mem_code_reg))
      else $error("straps changed after lock");

   core_rsvd_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_straps_locked && core_code_reg == `CORE_CODE_RSVD |=> o_config_error)
      else $error("reserved core code not flagged");

   core_ratio_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_straps_locked && core_code_reg == `CORE_CODE_9_2 |=>
      o_core_ratio.numer == 4'h9 && o_core_ratio.denom == 2'h2)
      else $error("core 9:2 decode wrong");

   mem_sync_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_straps_locked && mem_code_reg == `MEM_CODE_SYNC |=>
      o_mem_clock.sync_mode && o_mem_clock.mult == 4'h0)
      else $error("sync mode not selected");

   mem_mult_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_straps_locked && mem_code_reg == `MEM_CODE_12_1 |=>
      !o_mem_clock.sync_mode && o_mem_clock.mult == 4'hc)
      else $error("memory 12:1 decode wrong");

   divider_freeze_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      $past(i_memory_init_started) && i_memory_init_started |->
      $stable(o_mem_clock.half_speed))
      else $error("divider changed after init");

   pci_source_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      !sys_in_range |=> o_pci_clock_from_dedicated)
      else $error("PCI source not dedicated");

   pcie_check_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_negotiated_link_width == 5'h8 && i_platform_bus_clock_mhz == 16'h020e
      |=> o_pcie_platform_too_slow)
      else $error("PCIe minimum not enforced");

endmodule // clock_ratio_strap_decode

/* core_ratio_decode.sv */
`timescale 1ns/1ns
`include "clock_ratio_defines.svh"

module core_ratio_decode
   import clock_ratio_pkg::*;
(
   input  wire logic [2:0]  i_code,
   output core_ratio_t      o_ratio,
   output logic             o_reserved
);

   always_comb begin
      o_reserved = 1'b0;
      unique case (i_code)
         `CORE_CODE_4_1: o_ratio = '{numer: 4'h4, denom: 2'h1};
         `CORE_CODE_9_2: o_ratio = '{numer: 4'h9, denom: 2'h2};
         `CORE_CODE_3_2: o_ratio = '{numer: 4'h3, denom: 2'h2};
         `CORE_CODE_2_1: o_ratio = '{numer: 4'h2, denom: 2'h1};
         `CORE_CODE_5_2: o_ratio = '{numer: 4'h5, denom: 2'h2};
         `CORE_CODE_3_1: o_ratio = '{numer: 4'h3, denom: 2'h1};
         `CORE_CODE_7_2: o_ratio = '{numer: 4'h7, denom: 2'h2};
         `CORE_CODE_RSVD: begin
            o_ratio    = '{numer: 4'h0, denom: 2'h0};
            o_reserved = 1'b1;
         end
      endcase
   end

endmodule // core_ratio_decode

/* test_clock_ratio_strap_decode.sv */
`timescale 1ns/1ns
module test_clock_ratio_strap_decode;
   import clock_ratio_pkg::*;
   logic        mclk, reset, divider, init_started, pci_async;
   logic [2:0]  core_code, mem_code, core_pins, mem_pins;
   logic [7:0]  sys_mhz;
   logic [15:0] plat_mhz;
   logic [4:0]  width;
   core_ratio_t core_ratio;
   mem_clock_t  mem_clock;
   logic        ref_needed, pci_ded, pci_ok, too_slow, cfg_err, locked;
   int          n_errors, check_count, k, i, w;
   int          numer_t[8] = '{4, 9, 0, 3, 2, 5, 3, 7};
   int          denom_t[8] = '{1, 2, 0, 2, 1, 2, 1, 2};
   int          mult_t[8]  = '{3, 4, 6, 8, 10, 12, 0, 0};

   board_straps board (.i_core_code(core_code), .i_mem_code(mem_code),
                       .o_core_pins(core_pins), .o_mem_pins(mem_pins));

   clock_ratio_strap_decode dut (
      .i_mclk(mclk), .i_reset(reset),
      .i_local_bus_control_strap(core_pins[2]),
      .i_address_latch_enable_strap(core_pins[1]),
      .i_general_purpose_line_two_strap(core_pins[0]),
      .i_timestamp_trigger_output_pins(mem_pins[2:1]),
      .i_timestamp_clock_output_pin(mem_pins[0]),
      .i_memory_clock_divider_register(divider),
      .i_memory_init_started(init_started), .i_pci_async_mode(pci_async),
      .i_system_reference_clock_mhz(sys_mhz), .i_platform_bus_clock_mhz(plat_mhz),
      .i_negotiated_link_width(width), .o_core_ratio(core_ratio),
      .o_mem_clock(mem_clock), .o_mem_ref_clock_needed(ref_needed),
      .o_pci_clock_from_dedicated(pci_ded), .o_pci_clock_in_range(pci_ok),
      .o_pcie_platform_too_slow(too_slow), .o_config_error(cfg_err),
      .o_straps_locked(locked));

   always #4 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Straps are set up before release and held through the capture edge.
   task automatic boot(input logic [2:0] c, input logic [2:0] m);
      int j;
      reset <= 1'b1;
      core_code <= c;
      mem_code <= m;
      cyc(5);
      chk("rst_core", 16'h0001, {10'h0, core_ratio});
      chk("rst_mem", 16'h0020, {10'h0, mem_clock});
      chk("rst_locked", 16'h0, {15'h0, locked});
      reset <= 1'b0;
      j = 0;
      while (locked !== 1'b1 && j < 10) begin
         cyc(1);
         j++;
      end
      chk("locked", 16'h1, {15'h0, locked});
      if (locked !== 1'b1) begin
         end_sim();
      end
      cyc(2);
   endtask

   task automatic chk_ratios(input logic [2:0] c, input logic [2:0] m);
      chk("core", {10'h0, 4'(numer_t[c]), 2'(denom_t[c])}, {10'h0, core_ratio});
      chk("cfg_err", {15'h0, c == 3'h2 || m == 3'h6}, {15'h0, cfg_err});
      if (m != 3'h6) begin
         chk("mem", {10'h0, m == 3'h7, 4'(mult_t[m]), 1'b0},
             {10'h0, mem_clock});
         chk("ref_needed", {15'h0, m != 3'h7}, {15'h0, ref_needed});
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      reset = 1'b1;
      divider = 1'b0;
      init_started = 1'b0;
      pci_async = 1'b0;
      core_code = 3'h0;
      mem_code = 3'h0;
      sys_mhz = 8'h42;
      plat_mhz = 16'h0210;
      width = 5'h1;
      n_errors = 0;
      check_count = 0;
      void'($urandom(32'h64511fe0));
      // Every code of both straps, then a strap change after capture.
      for (k = 0; k < 8; k++) begin
         boot(3'(k), 3'(k + 3));
         core_code <= ~core_code;
         mem_code <= ~mem_code;
         cyc(3);
         chk_ratios(3'(k), 3'(k + 3));
      end
      divider <= 1'b1;
      cyc(2);
      chk("half", 16'h1, {15'h0, mem_clock.half_speed});
      init_started <= 1'b1;
      divider <= 1'b0;
      cyc(3);
      chk("half_frozen", 16'h1, {15'h0, mem_clock.half_speed});
      // Values straddle both PCI limits and the PCI Express threshold.
      for (i = 0; i < 60; i++) begin
         w = 1 << $urandom_range(0, 3);
         sys_mhz <= 8'(31 + $urandom_range(0, 37));
         width <= 5'(w);
         plat_mhz <= 16'((527 * w) / 8 + $urandom_range(0, 3) - 1);
         pci_async <= 1'($urandom_range(0, 1));
         cyc(2);
         chk("pci_ded", {15'h0, pci_async || sys_mhz < 33 || sys_mhz > 66},
             {15'h0, pci_ded});
         chk("pci_ok", {15'h0, pci_async || (sys_mhz >= 33 && sys_mhz <= 66)},
             {15'h0, pci_ok});
         chk("too_slow", {15'h0, 32'(plat_mhz) * 8 < 527 * w}, {15'h0, too_slow});
      end
      end_sim();
   end
endmodule // test_clock_ratio_strap_decode
